// *** cas_core.sv ***
// Execution datapath for set, subtract, swap, exclusive-OR, skip and sleep
`include "cas_cfg.svh"
// Summary of operation
// - Whole-register set writes all ones to the register in one cycle with no flag change.
// - Bit set forces the selected bit to one, keeps the rest, one cycle, no flag change.
// - Sleep halts the core, keeps port states, and updates the expiry and sleep flags.
// - Immediate subtract puts immediate minus working reg into working reg and sets four flags.
// - Register subtract puts register minus working reg into either target and sets four flags.
// - Borrow subtract also takes away the carry bit, to either target, setting four flags.
// - Swap exchanges the nibbles of the register into either target in one cycle, no flags.
// - Skip-if-clear skips the next instruction when the selected bit is zero, no flags.
// - Skip-if-set skips the next instruction when the selected bit is one, no flags.
// - Move-and-skip copies the register to a target and skips when it is zero, zero flag kept.
// - Increment-and-skip adds one to the register into a target and skips when the result is zero, no flags.
// - Decrement-and-skip takes one from the register into a target and skips when the result is zero, no flags.
// - Zero test writes the register back unchanged and sets zero from its value in one cycle.
// - Immediate exclusive-OR updates the working reg and only the zero flag in one cycle.
// - Register exclusive-OR goes to either target and updates only the zero flag.
module cas_core #(
  parameter int DATA_W = `CAS_DATA_W,
  parameter int BIT_SEL_W = `CAS_BIT_SEL_W
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic instr_valid,
  input cas_pkg::cas_instr_t instr,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic wake,
  input wire logic watchdog_expire,
  output logic [DATA_W-1:0] working_reg,
  output cas_pkg::cas_flags_t status,
  output logic reg_wr_en,
  output logic [DATA_W-1:0] reg_wdata,
  output logic skip_pending,
  output logic instr_discard,
  output logic core_halted
);
  import cas_pkg::*;

  localparam int HALF = DATA_W / 2;

  logic [DATA_W-1:0] next_working_reg;
  cas_flags_t next_status;
  logic next_reg_wr_en;
  logic [DATA_W-1:0] next_reg_wdata;
  logic next_skip_pending;
  logic next_core_halted;

  logic [DATA_W-1:0] sub_a;
  logic [DATA_W-1:0] sub_b;
  logic sub_cin;
  cas_sub_res_t sub_res;
  logic [DATA_W-1:0] swapped;
  logic [DATA_W-1:0] plus_one;
  logic [DATA_W-1:0] minus_one;
  logic [DATA_W-1:0] exor_reg;
  logic [DATA_W-1:0] exor_imm;
  logic sel_bit;
  logic go;

  // Package operand types are fixed at the native widths, so refuse others when building
  if (DATA_W != `CAS_DATA_W || BIT_SEL_W != `CAS_BIT_SEL_W)
  begin : gen_width_check
    $error("cas_core serves only the native data and bit select widths");
  end

  cas_sub #(
    .DATA_W(DATA_W)
  ) u_sub (
    .minuend(sub_a),
    .subtrahend(sub_b),
    .borrow_in(sub_cin),
    .res(sub_res)
  );

  // Operand steering for the shared subtractor
  always_comb
  begin
    sub_b = working_reg;
    sub_cin = 1'b0;
    sub_a = reg_rdata;
    if (instr.op == imm_minus_work_op)
      sub_a = instr.imm;
    if (instr.op == borrow_minus_to_work || instr.op == borrow_minus_to_reg)
      sub_cin = status.carry;
  end

  always_comb
  begin
    swapped = {reg_rdata[HALF-1:0], reg_rdata[DATA_W-1:HALF]};
    plus_one = reg_rdata + `CAS_ONE;
    minus_one = reg_rdata - `CAS_ONE;
    exor_reg = reg_rdata ^ working_reg;
    exor_imm = instr.imm ^ working_reg;
    sel_bit = reg_rdata[instr.bit_sel];
  end

  assign instr_discard = instr_valid && skip_pending && !core_halted;
  assign go = instr_valid && !skip_pending && !core_halted;

  always_comb
  begin
    next_working_reg = working_reg;
    next_status = status;
    next_reg_wr_en = 1'b0;
    next_reg_wdata = reg_wdata;
    next_skip_pending = skip_pending;
    next_core_halted = core_halted;
    if (wake)
      next_core_halted = 1'b0;
    if (instr_discard)
      next_skip_pending = 1'b0;
    if (go)
    begin
      case (instr.op)
        set_all_op:
        begin
          next_reg_wr_en = 1'b1;
          next_reg_wdata = `CAS_ALL_ONES;
        end
        bit_force_one_op:
        begin
          next_reg_wr_en = 1'b1;
          next_reg_wdata = reg_rdata | (DATA_W'(`CAS_ONE) << instr.bit_sel);
        end
        sleep_op:
        begin
          next_core_halted = 1'b1;
          next_status.sleep_entered_flag = 1'b1;
          next_status.watchdog_expiry_flag = 1'b0;
        end
        imm_minus_work_op, reg_minus_work_to_work, borrow_minus_to_work:
        begin
          next_working_reg = sub_res.diff;
          next_status.carry = sub_res.borrow;
          next_status.half_borrow_bit = sub_res.half_borrow;
          next_status.zero = sub_res.zero;
          next_status.signed_range_flag = sub_res.ovf;
        end
        reg_minus_work_to_reg, borrow_minus_to_reg:
        begin
          next_reg_wr_en = 1'b1;
          next_reg_wdata = sub_res.diff;
          next_status.carry = sub_res.borrow;
          next_status.half_borrow_bit = sub_res.half_borrow;
          next_status.zero = sub_res.zero;
          next_status.signed_range_flag = sub_res.ovf;
        end
        nibble_exch_to_work:
          next_working_reg = swapped;
        nibble_exch_to_reg:
        begin
          next_reg_wr_en = 1'b1;
          next_reg_wdata = swapped;
        end
        skip_bit_low_op:
          next_skip_pending = !sel_bit;
        skip_bit_high_op:
          next_skip_pending = sel_bit;
        move_skip_null_work:
        begin
          next_working_reg = reg_rdata;
          next_skip_pending = (reg_rdata == `CAS_ALL_ZERO);
        end
        move_skip_null_reg:
        begin
          next_reg_wr_en = 1'b1;
          next_reg_wdata = reg_rdata;
          next_skip_pending = (reg_rdata == `CAS_ALL_ZERO);
        end
        incr_skip_to_work:
        begin
          next_working_reg = plus_one;
          next_skip_pending = (plus_one == `CAS_ALL_ZERO);
        end
        incr_skip_to_reg:
        begin
          next_reg_wr_en = 1'b1;
          next_reg_wdata = plus_one;
          next_skip_pending = (plus_one == `CAS_ALL_ZERO);
        end
        decr_skip_to_work:
        begin
          next_working_reg = minus_one;
          next_skip_pending = (minus_one == `CAS_ALL_ZERO);
        end
        decr_skip_to_reg:
        begin
          next_reg_wr_en = 1'b1;
          next_reg_wdata = minus_one;
          next_skip_pending = (minus_one == `CAS_ALL_ZERO);
        end
        null_check_op:
        begin
          next_reg_wr_en = 1'b1;
          next_reg_wdata = reg_rdata;
          next_status.zero = (reg_rdata == `CAS_ALL_ZERO);
        end
        imm_exor_op:
        begin
          next_working_reg = exor_imm;
          next_status.zero = (exor_imm == `CAS_ALL_ZERO);
        end
        reg_exor_to_work:
        begin
          next_working_reg = exor_reg;
          next_status.zero = (exor_reg == `CAS_ALL_ZERO);
        end
        reg_exor_to_reg:
        begin
          next_reg_wr_en = 1'b1;
          next_reg_wdata = exor_reg;
          next_status.zero = (exor_reg == `CAS_ALL_ZERO);
        end
        default:
        begin
          next_working_reg = working_reg;
        end
      endcase
    end
    // Expiry event wins over the clear done by sleep in the same cycle
    if (watchdog_expire)
      next_status.watchdog_expiry_flag = 1'b1;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      working_reg <= `CAS_WORK_RST;
      status <= '0;
      reg_wr_en <= 1'b0;
      reg_wdata <= `CAS_ALL_ZERO;
      skip_pending <= 1'b0;
      core_halted <= 1'b0;
    end
    else
    begin
      working_reg <= next_working_reg;
      status <= next_status;
      reg_wr_en <= next_reg_wr_en;
      reg_wdata <= next_reg_wdata;
      skip_pending <= next_skip_pending;
      core_halted <= next_core_halted;
    end
  end
endmodule

// *** cas_cfg.svh ***
// Widths and constant values for the skip and subtract datapath
`ifndef CAS_CFG_SVH
`define CAS_CFG_SVH
`define CAS_DATA_W 8
`define CAS_BIT_SEL_W 3
`define CAS_ALL_ONES 8'hff
`define CAS_ALL_ZERO 8'h00
`define CAS_ONE 8'h01
`define CAS_WORK_RST 8'h00
`define CAS_NIBBLE_W 4
`endif

// *** cas_pkg.sv ***
// Types shared by the datapath files
`include "cas_cfg.svh"
package cas_pkg;
  typedef enum logic [4:0] {
    nop_op,
    set_all_op,
    bit_force_one_op,
    sleep_op,
    imm_minus_work_op,
    reg_minus_work_to_work,
    reg_minus_work_to_reg,
    borrow_minus_to_work,
    borrow_minus_to_reg,
    nibble_exch_to_work,
    nibble_exch_to_reg,
    skip_bit_low_op,
    skip_bit_high_op,
    move_skip_null_work,
    move_skip_null_reg,
    incr_skip_to_work,
    incr_skip_to_reg,
    decr_skip_to_work,
    decr_skip_to_reg,
    null_check_op,
    imm_exor_op,
    reg_exor_to_work,
    reg_exor_to_reg
  } cas_op_t;

  typedef struct packed {
    cas_op_t op;
    logic [`CAS_DATA_W-1:0] imm;
    logic [`CAS_BIT_SEL_W-1:0] bit_sel;
  } cas_instr_t;

  typedef struct packed {
    logic carry;
    logic half_borrow_bit;
    logic zero;
    logic signed_range_flag;
    logic watchdog_expiry_flag;
    logic sleep_entered_flag;
  } cas_flags_t;

  typedef struct packed {
    logic [`CAS_DATA_W-1:0] diff;
    logic borrow;
    logic half_borrow;
    logic zero;
    logic ovf;
  } cas_sub_res_t;
endpackage

// *** cas_sub.sv ***
// Subtractor with borrow in, borrow, half borrow, zero and overflow out
`include "cas_cfg.svh"
module cas_sub #(
  parameter int DATA_W = `CAS_DATA_W
) (
  input wire logic [DATA_W-1:0] minuend,
  input wire logic [DATA_W-1:0] subtrahend,
  input wire logic borrow_in,
  output cas_pkg::cas_sub_res_t res
);
  import cas_pkg::*;

  localparam int HALF = DATA_W / 2;

  logic [DATA_W:0] full;
  logic [HALF:0] low;

  // The result struct carries a native-width difference
  if (DATA_W != `CAS_DATA_W)
  begin : gen_width_check
    $error("cas_sub serves only the native data width");
  end

  always_comb
  begin
    full = {1'b0, minuend} - {1'b0, subtrahend} - {{DATA_W{1'b0}}, borrow_in};
    low = {1'b0, minuend[HALF-1:0]} - {1'b0, subtrahend[HALF-1:0]}
      - {{HALF{1'b0}}, borrow_in};
    res.diff = full[DATA_W-1:0];
    // A set top bit of the widened result means the subtraction wrapped
    res.borrow = full[DATA_W];
    res.half_borrow = low[HALF];
    res.zero = (full[DATA_W-1:0] == `CAS_ALL_ZERO);
    // Signed overflow: operands of opposite sign, result sign differs from minuend
    res.ovf = (minuend[DATA_W-1] != subtrahend[DATA_W-1])
      && (full[DATA_W-1] != minuend[DATA_W-1]);
  end
endmodule

// *** cas_core_props.sv ***
// Port-level assertions for the skip and subtract datapath
module cas_core_props (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic instr_valid,
  input cas_pkg::cas_instr_t instr,
  input wire logic [7:0] reg_rdata,
  input wire logic wake,
  input wire logic watchdog_expire,
  input wire logic [7:0] working_reg,
  input cas_pkg::cas_flags_t status,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wdata,
  input wire logic skip_pending,
  input wire logic instr_discard,
  input wire logic core_halted
);
  timeunit 1ns;
  timeprecision 1ps;
  import cas_pkg::*;
  logic go;
  logic q;
  logic sel_bit;
  assign go = instr_valid && !skip_pending && !core_halted;
  // A watchdog event may touch the flags, so the set, bit force, sleep and swap checks skip that cycle
  assign q = go && !watchdog_expire;
  assign sel_bit = reg_rdata[instr.bit_sel];
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  a_set_all_ones:
    assert property (q && instr.op == set_all_op |=> reg_wr_en && reg_wdata == 8'hff
      && status == $past(status)) else $error("set all result wrong");
  a_bit_force_one:
    assert property (q && instr.op == bit_force_one_op |=> reg_wr_en && status == $past(status)
      && reg_wdata == ($past(reg_rdata) | (8'h01 << $past(instr.bit_sel))))
      else $error("bit force result wrong");
  a_sleep_halts:
    assert property (q && instr.op == sleep_op |=> core_halted
      && status.sleep_entered_flag && !status.watchdog_expiry_flag)
      else $error("sleep entry wrong");
  a_halt_freezes:
    assert property (core_halted && !wake && !watchdog_expire |=> !reg_wr_en
      && $stable(working_reg) && $stable(status)) else $error("halted core changed");
  a_imm_sub_result:
    assert property (go && instr.op == imm_minus_work_op |=>
      working_reg == 8'($past(instr.imm) - $past(working_reg))
      && status.carry == ($past(instr.imm) < $past(working_reg)))
      else $error("immediate subtract wrong");
  a_swap_keeps_flags:
    assert property (q && instr.op == nibble_exch_to_reg |=> reg_wr_en
      && reg_wdata == {$past(reg_rdata[3:0]), $past(reg_rdata[7:4])}
      && status == $past(status)) else $error("swap result wrong");
  a_skip_low_bit:
    assert property (go && instr.op == skip_bit_low_op |=> skip_pending == !$past(sel_bit)
      && !reg_wr_en) else $error("skip on clear bit wrong");
  a_discard_next:
    assert property (skip_pending && instr_valid && !core_halted |-> instr_discard
      ##1 !skip_pending && !reg_wr_en && $stable(working_reg))
      else $error("skipped instruction not discarded");
endmodule
bind cas_core cas_core_props cas_core_props_i (.clk_sys, .rst, .instr_valid, .instr,
  .reg_rdata, .wake, .watchdog_expire, .working_reg, .status, .reg_wr_en, .reg_wdata,
  .skip_pending, .instr_discard, .core_halted);

// *** testbench.sv ***
// Self-checking bench for the skip and subtract datapath
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import cas_pkg::*;
  typedef struct packed {
    logic [7:0] w;
    cas_flags_t f;
    logic wr;
    logic [7:0] d;
    logic sk;
    logic h;
  } cas_note_t;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0;
  cas_instr_t instr = 16'h0000;
  logic [7:0] reg_rdata = 8'h00;
  logic wake = 1'b0;
  logic watchdog_expire = 1'b0;
  logic [7:0] working_reg;
  cas_flags_t status;
  logic reg_wr_en;
  logic [7:0] reg_wdata;
  logic skip_pending;
  logic instr_discard;
  logic core_halted;
  cas_note_t m;
  cas_note_t n;
  cas_note_t notes[$];
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int k;
  integer seed = 32'hd804e684;
  cas_instr_t ri;
  cas_core cas_core_i (.clk_sys, .rst, .instr_valid, .instr, .reg_rdata, .wake,
    .watchdog_expire, .working_reg, .status, .reg_wr_en, .reg_wdata, .skip_pending,
    .instr_discard, .core_halted);
  initial forever #12.5 clk_sys = ~clk_sys;
  task automatic end_of_test();
    if (bad_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic logic [7:0] sub(input logic [7:0] a, input logic [7:0] b, input logic c);
    logic [8:0] r;
    logic [4:0] h;
    r = {1'b0, a} - {1'b0, b} - {8'h00, c};
    h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, c};
    m.f.carry = r[8];
    m.f.half_borrow_bit = h[4];
    m.f.zero = r[7:0] == 8'h00;
    m.f.signed_range_flag = (a[7] != b[7]) && (r[7] != a[7]);
    return r[7:0];
  endfunction
  function automatic void model(input cas_instr_t i, input logic [7:0] rd);
    logic [7:0] v;
    logic tw;
    case (i.op)
      set_all_op: v = 8'hff;
      bit_force_one_op: v = rd | (8'h01 << i.bit_sel);
      imm_minus_work_op: v = sub(i.imm, m.w, 1'b0);
      reg_minus_work_to_work, reg_minus_work_to_reg: v = sub(rd, m.w, 1'b0);
      borrow_minus_to_work, borrow_minus_to_reg: v = sub(rd, m.w, m.f.carry);
      nibble_exch_to_work, nibble_exch_to_reg: v = {rd[3:0], rd[7:4]};
      incr_skip_to_work, incr_skip_to_reg: v = rd + 8'h01;
      decr_skip_to_work, decr_skip_to_reg: v = rd - 8'h01;
      imm_exor_op: v = i.imm ^ m.w;
      reg_exor_to_work, reg_exor_to_reg: v = rd ^ m.w;
      default: v = rd;
    endcase
    if (i.op == skip_bit_low_op) m.sk = !rd[i.bit_sel];
    else if (i.op == skip_bit_high_op) m.sk = rd[i.bit_sel];
    else m.sk = i.op inside {[move_skip_null_work:decr_skip_to_reg]} && v == 8'h00;
    if (i.op inside {[null_check_op:reg_exor_to_reg]}) m.f.zero = v == 8'h00;
    m.h = i.op == sleep_op;
    if (m.h) m.f[1:0] = 2'b01;
    tw = i.op inside {imm_minus_work_op, reg_minus_work_to_work, borrow_minus_to_work,
      nibble_exch_to_work, move_skip_null_work, incr_skip_to_work, decr_skip_to_work,
      imm_exor_op, reg_exor_to_work};
    if (tw) m.w = v;
    m.wr = !tw && !(i.op inside {nop_op, sleep_op, skip_bit_low_op, skip_bit_high_op});
    if (m.wr) m.d = v;
  endfunction
  task automatic exec(input cas_instr_t i, input logic [7:0] rd, input logic wd, input logic wk);
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr <= i;
    reg_rdata <= rd;
    watchdog_expire <= wd;
    wake <= wk;
    #1;
    check("instr_discard", instr_discard, m.sk && !m.h);
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    watchdog_expire <= 1'b0;
    wake <= 1'b0;
    m.wr = 1'b0;
    // Halted core ignores the slot; a pending skip eats exactly this one
    if (m.h) m.h = !wk;
    else if (m.sk) m.sk = 1'b0;
    else model(i, rd);
    if (wd) m.f.watchdog_expiry_flag = 1'b1;
    notes.push_back(m);
  endtask
  task automatic do_reset();
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    check("reset", {working_reg, status, reg_wr_en, reg_wdata, skip_pending, core_halted,
      instr_discard}, 32'h0);
    @(posedge clk_sys);
    rst <= 1'b0;
    m = '0;
  endtask
  always @(negedge clk_sys)
    if (notes.size() > 0)
    begin
      n = notes.pop_front();
      check("state", {working_reg, status, reg_wr_en, skip_pending, core_halted},
        {n.w, n.f, n.wr, n.sk, n.h});
      if (n.wr) check("reg_wdata", reg_wdata, n.d);
    end
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      end_of_test();
    end
  end
  initial
  begin
    do_reset();
    // Borrow subtract with carry set: 80 - 77 - 1
    exec('{imm_exor_op, 8'h77, 3'h0}, 8'h00, 1'b0, 1'b0);
    exec('{imm_minus_work_op, 8'h00, 3'h0}, 8'h00, 1'b0, 1'b0);
    exec('{imm_exor_op, 8'hfe, 3'h0}, 8'h00, 1'b0, 1'b0);
    exec('{borrow_minus_to_work, 8'h00, 3'h0}, 8'h80, 1'b0, 1'b0);
    for (int j = 0; j < 600; j++)
    begin
      k = $unsigned($random(seed)) % 23;
      ri.op = (cas_op_t'(k[4:0]) == sleep_op) ? nop_op : cas_op_t'(k[4:0]);
      ri.imm = 8'($random(seed));
      ri.bit_sel = 3'($random(seed));
      exec(ri, 8'($random(seed)), ($random(seed) & 15) == 0, 1'b0);
    end
    exec('{nop_op, 8'h00, 3'h0}, 8'h00, 1'b0, 1'b0);
    exec('{sleep_op, 8'h00, 3'h0}, 8'h00, 1'b0, 1'b0);
    exec('{set_all_op, 8'h00, 3'h0}, 8'h12, 1'b0, 1'b0);
    exec('{reg_exor_to_work, 8'h00, 3'h0}, 8'h34, 1'b1, 1'b0);
    exec('{nop_op, 8'h00, 3'h0}, 8'h00, 1'b0, 1'b1);
    exec('{incr_skip_to_work, 8'h00, 3'h0}, 8'hff, 1'b0, 1'b0);
    exec('{set_all_op, 8'h00, 3'h0}, 8'h00, 1'b0, 1'b0);
    do_reset();
    exec('{nibble_exch_to_reg, 8'h00, 3'h0}, 8'h35, 1'b0, 1'b0);
    repeat (2) @(posedge clk_sys);
    end_of_test();
  end
endmodule
